/* rtl/vr_sup_pkg.sv */
// Constants and types shared by the regulator supervisor design.
// Assumes a 10 MHz system clock.
package vr_sup_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CODE_W = 6;
  // Code skew guard: least time, rounded up
  localparam int unsigned CODE_GUARD_NS = 400;
  localparam int unsigned CODE_GUARD_CYC =
    (CODE_GUARD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Blanking after a code change: least time, rounded up
  localparam int unsigned BLANK_US = 250;
  localparam int unsigned BLANK_CYC = BLANK_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BLANK_W = 12;
  localparam int unsigned GUARD_W = 4;
  // Phase selection and register widths
  localparam int unsigned PHASE_MAX = 4;
  localparam int unsigned PHASE_SEL_W = 2;
  localparam logic [PHASE_SEL_W-1:0] PHASE_SEL_RST = 2'h1;
  localparam int unsigned AXI_AW = 4;
  // Register byte addresses
  localparam logic [AXI_AW-1:0] REG_CTRL = 4'h0;
  localparam logic [AXI_AW-1:0] REG_STATUS = 4'h4;
  localparam logic [AXI_AW-1:0] REG_CODE = 4'h8;
  // Control register fields
  localparam int unsigned CTRL_PHASE_LSB = 0;
  localparam int unsigned CTRL_CLK_DIV_LSB = 8;
  localparam int unsigned CLK_DIV_W = 8;
  localparam logic [CLK_DIV_W-1:0] CLK_DIV_RST = 8'h09;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_DISABLED,
    ST_SOFT_START,
    ST_NORMAL,
    ST_LIMIT_DELAY,
    ST_LATCHED
  } sup_state_t;
endpackage

/* rtl/vr_code_if.sv */
// Carries the accepted voltage code and blanking status between modules.
// Assumes one clock domain.
`timescale 1ns/100ps
interface vr_code_if;
  import vr_sup_pkg::*;
  logic [CODE_W-1:0] code;
  logic code_valid;
  logic blank;
  logic all_high;
  modport src (output code, output code_valid, output blank, output all_high);
  modport dst (input code, input code_valid, input blank, input all_high);
endinterface

/* rtl/vr_code_watch.sv */
// Voltage code deglitch, on-the-fly detection and blanking timer.
// Assumes code pins synchronous to sys_clk_in.
`timescale 1ns/100ps
module vr_code_watch
  import vr_sup_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic [CODE_W-1:0] voltage_code_inputs_in,
  vr_code_if.src code_out
);
  typedef struct packed {
    logic [CODE_W-1:0] last;
    logic [CODE_W-1:0] code;
    logic [GUARD_W-1:0] guard;
    logic [BLANK_W-1:0] blank_cnt;
    logic valid;
  } watch_t;
  watch_t st_ff;
  watch_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.last = voltage_code_inputs_in;
    if (voltage_code_inputs_in != st_ff.last) begin
      nxt_st.guard = GUARD_W'(CODE_GUARD_CYC);
      if (run_in && st_ff.valid) begin
        nxt_st.blank_cnt = BLANK_W'(BLANK_CYC);
      end
    end else if (st_ff.guard != '0) begin
      nxt_st.guard = st_ff.guard - 1'b1;
    end else begin
      nxt_st.code = st_ff.last;
      nxt_st.valid = 1'b1;
    end
    if (voltage_code_inputs_in == st_ff.last && st_ff.blank_cnt != '0) begin
      nxt_st.blank_cnt = st_ff.blank_cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign code_out.code = st_ff.code;
  assign code_out.code_valid = st_ff.valid;
  assign code_out.blank = st_ff.blank_cnt != '0;
  assign code_out.all_high = st_ff.valid && (&st_ff.code);
endmodule

/* rtl/vr_phase_clk.sv */
// Master clock enable divider and phase rotation.
// Assumes a single system clock; outputs are one-cycle enables.
`timescale 1ns/100ps
module vr_phase_clk
  import vr_sup_pkg::*;
#(
  parameter int unsigned PHASES = PHASE_MAX
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic [CLK_DIV_W-1:0] clk_div_in,
  input wire logic [PHASE_SEL_W-1:0] phase_sel_in,
  output logic [PHASES-1:0] phase_tick_out
);
  typedef struct packed {
    logic [CLK_DIV_W-1:0] div;
    logic [PHASE_SEL_W-1:0] phase;
    logic [PHASES-1:0] tick;
  } pclk_t;
  pclk_t st_ff;
  pclk_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = '0;
    if (!run_in) begin
      nxt_st = '0;
    end else if (st_ff.div >= clk_div_in) begin
      nxt_st.div = '0;
      nxt_st.tick[st_ff.phase] = 1'b1;
      nxt_st.phase = (st_ff.phase >= phase_sel_in) ? '0 : st_ff.phase + 1'b1;
    end else begin
      nxt_st.div = st_ff.div + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign phase_tick_out = st_ff.tick;
endmodule

/* rtl/vr_fault_and_sequence_supervisor.sv */
// Fault sequencing, power-good, clamp and enable gating of the regulator.
// Assumes comparator results arrive synchronous to sys_clk_in.
`timescale 1ns/100ps
module vr_fault_and_sequence_supervisor
  import vr_sup_pkg::*;
#(
  parameter int unsigned PHASES = PHASE_MAX
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic [CODE_W-1:0] voltage_code_inputs_in,
  input wire logic current_limit_cmp_in,
  input wire logic ramp_above_2v8_in,
  input wire logic ramp_below_1v8_in,
  input wire logic ramp_at_top_in,
  input wire logic out_in_window_in,
  input wire logic out_over_limit_in,
  input wire logic out_below_700mv_in,
  input wire logic out_below_200mv_in,
  input wire logic [PHASES-1:0] pwm_request_in,
  output logic [PHASES-1:0] pwm_enable_out,
  output logic output_good_flag_out,
  output logic output_good_flag_oe_n_out,
  output logic ramp_charge_out,
  output logic ramp_pullup_out,
  output logic ramp_short_out,
  output logic limit_set_pin_out,
  output logic limit_active_out,
  output logic startup_clamp_out,
  output logic [CODE_W-1:0] dac_code_out,
  output logic [PHASES-1:0] phase_tick_out,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    sup_state_t state;
    logic clamp;
    logic good;
    logic [PHASES-1:0] pwm;
    logic [PHASE_SEL_W-1:0] phase_sel;
    logic [CLK_DIV_W-1:0] clk_div;
    logic aw_got;
    logic w_got;
    logic [AXI_AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic latch_seen;
  } sup_t;
  sup_t st_ff;
  sup_t nxt_st;

  vr_code_if code_bus ();
  logic running;
  logic [PHASES-1:0] phase_mask;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic do_write;

  // Switching allowed only when out of lockout, enabled and not latched
  assign running = enable_in && (st_ff.state inside {ST_SOFT_START, ST_NORMAL,
    ST_LIMIT_DELAY});

  vr_code_watch u_code (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .run_in(running),
    .voltage_code_inputs_in(voltage_code_inputs_in),
    .code_out(code_bus.src)
  );

  vr_phase_clk #(.PHASES(PHASES)) u_pclk (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .run_in(running),
    .clk_div_in(st_ff.clk_div),
    .phase_sel_in(st_ff.phase_sel),
    .phase_tick_out(phase_tick_out)
  );

  always_comb begin
    for (int i = 0; i < PHASES; i++) begin
      phase_mask[i] = (i <= int'(st_ff.phase_sel));
    end
  end

  assign ctrl_word = {16'h0000, st_ff.clk_div, 6'h00, st_ff.phase_sel};
  assign status_word = {16'h0000, 2'h0, code_bus.code, st_ff.latch_seen,
    code_bus.blank, st_ff.clamp, st_ff.good, 1'b0, 3'(st_ff.state)};
  assign do_write = (st_ff.aw_got || s_axi_awvalid) && (st_ff.w_got || s_axi_wvalid)
    && !st_ff.bvalid;

  always_comb begin
    logic [AXI_AW-1:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    wa = st_ff.aw_got ? st_ff.awaddr : s_axi_awaddr;
    wd = st_ff.w_got ? st_ff.wdata : s_axi_wdata;
    ws = st_ff.w_got ? st_ff.wstrb : s_axi_wstrb;
    nxt_st = st_ff;

    // Fault sequencer
    if (!enable_in) begin
      nxt_st.state = ST_DISABLED;
    end else begin
      unique case (st_ff.state)
        ST_DISABLED: nxt_st.state = ST_SOFT_START;
        ST_SOFT_START: begin
          if (current_limit_cmp_in) begin
            nxt_st.state = ST_LIMIT_DELAY;
          end else if (ramp_at_top_in) begin
            nxt_st.state = ST_NORMAL;
          end
        end
        ST_NORMAL: begin
          if (current_limit_cmp_in) begin
            nxt_st.state = ST_LIMIT_DELAY;
          end
        end
        ST_LIMIT_DELAY: begin
          if (ramp_below_1v8_in) begin
            nxt_st.state = ST_LATCHED;
          end else if (!current_limit_cmp_in) begin
            nxt_st.state = out_in_window_in ? ST_NORMAL : ST_SOFT_START;
          end
        end
        ST_LATCHED: nxt_st.state = ST_LATCHED;
        default: nxt_st.state = ST_DISABLED;
      endcase
    end
    if (nxt_st.state == ST_LATCHED) begin
      nxt_st.latch_seen = 1'b1;
    end

    // Overvoltage clamp, released below 700 mV
    if (!running) begin
      nxt_st.clamp = 1'b0;
    end else if (out_over_limit_in && !code_bus.blank) begin
      nxt_st.clamp = 1'b1;
    end else if (out_below_700mv_in) begin
      nxt_st.clamp = 1'b0;
    end

    // Power-good
    if (!enable_in || !running || !ramp_above_2v8_in || code_bus.all_high) begin
      nxt_st.good = 1'b0;
    end else if (!out_in_window_in) begin
      nxt_st.good = code_bus.blank ? st_ff.good : 1'b0;
    end else begin
      nxt_st.good = 1'b1;
    end

    // PWM gating
    if (!running || nxt_st.clamp) begin
      nxt_st.pwm = '0;
    end else begin
      nxt_st.pwm = pwm_request_in & phase_mask;
    end

    // Register write
    if (do_write) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = RESP_OKAY;
      if (wa == REG_CTRL) begin
        if (ws[0]) begin
          nxt_st.phase_sel = wd[CTRL_PHASE_LSB +: PHASE_SEL_W];
        end
        if (ws[1]) begin
          nxt_st.clk_div = wd[CTRL_CLK_DIV_LSB +: CLK_DIV_W];
        end
      end else if (wa == REG_STATUS) begin
        if (ws[0] && wd[3] && nxt_st.state != ST_LATCHED) begin
          nxt_st.latch_seen = 1'b0;
        end
      end else begin
        nxt_st.bresp = RESP_SLVERR;
      end
    end else begin
      if (s_axi_awvalid && !st_ff.aw_got) begin
        nxt_st.aw_got = 1'b1;
        nxt_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_ff.w_got) begin
        nxt_st.w_got = 1'b1;
        nxt_st.wdata = s_axi_wdata;
        nxt_st.wstrb = s_axi_wstrb;
      end
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // Register read
    if (s_axi_arvalid && !st_ff.rvalid) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        REG_CTRL: nxt_st.rdata = ctrl_word;
        REG_STATUS: nxt_st.rdata = status_word;
        REG_CODE: nxt_st.rdata = {26'h0, code_bus.code};
        default: begin
          nxt_st.rdata = 32'h0000_0000;
          nxt_st.rresp = RESP_SLVERR;
        end
      endcase
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= '0;
      st_ff.state <= ST_DISABLED;
      st_ff.phase_sel <= PHASE_SEL_RST;
      st_ff.clk_div <= CLK_DIV_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pwm_enable_out = st_ff.pwm;
  assign output_good_flag_out = 1'b0;
  assign output_good_flag_oe_n_out = st_ff.good;
  assign ramp_short_out = !running;
  assign ramp_charge_out = running;
  assign ramp_pullup_out = running && st_ff.state != ST_LIMIT_DELAY
    && !current_limit_cmp_in;
  assign limit_set_pin_out = running;
  assign limit_active_out = running && current_limit_cmp_in;
  assign startup_clamp_out = st_ff.state == ST_SOFT_START && out_below_200mv_in;
  assign dac_code_out = code_bus.code;
  assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
endmodule

/* sim/vr_sup_asserts.sv */
// Concurrent checks on the supervisor pins.
// Assumes one clock and an async active-low reset.
`timescale 1ns/100ps
module vr_sup_asserts
  import vr_sup_pkg::*;
#(
  parameter int unsigned PHASES = PHASE_MAX
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic [CODE_W-1:0] voltage_code_inputs_in,
  input wire logic current_limit_cmp_in,
  input wire logic ramp_above_2v8_in,
  input wire logic ramp_below_1v8_in,
  input wire logic out_below_200mv_in,
  input wire logic [PHASES-1:0] pwm_request_in,
  input wire logic [PHASES-1:0] pwm_enable_out,
  input wire logic output_good_flag_oe_n_out,
  input wire logic ramp_pullup_out,
  input wire logic ramp_short_out,
  input wire logic limit_set_pin_out,
  input wire logic limit_active_out,
  input wire logic startup_clamp_out,
  input wire logic [CODE_W-1:0] dac_code_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_off_pwm_low: assert property (
    !enable_in [*3] |-> pwm_enable_out == '0) else $error("pwm on while disabled");
  a_off_node_idle: assert property (
    !enable_in [*2] |-> ramp_short_out && !limit_set_pin_out) else $error("node not idle");
  a_limit_pullup: assert property (
    limit_active_out |-> !ramp_pullup_out) else $error("pull-up on in limit");
  a_limit_cause: assert property (
    limit_active_out |-> current_limit_cmp_in && !ramp_short_out)
    else $error("limit without cause");
  a_latch_stop: assert property (
    limit_active_out && ramp_below_1v8_in |-> ##2 pwm_enable_out == '0)
    else $error("no latch-off");
  a_limit_cycles: assert property (
    limit_active_out ##1 limit_active_out |-> pwm_enable_out == $past(pwm_request_in))
    else $error("phases stopped in limit");
  a_good_enable: assert property (
    !enable_in |=> !output_good_flag_oe_n_out) else $error("good with enable low");
  a_good_ramp: assert property (
    !ramp_above_2v8_in |=> !output_good_flag_oe_n_out) else $error("good before ramp");
  a_code_guard: assert property (
    $changed(voltage_code_inputs_in) |=> ##1 $stable(dac_code_out) [*3])
    else $error("code taken too soon");
  a_clamp_start: assert property (
    startup_clamp_out |-> out_below_200mv_in) else $error("startup clamp misplaced");
  c_limit: cover property (limit_active_out);
  c_latch: cover property (limit_active_out && ramp_below_1v8_in);
  c_code: cover property ($changed(dac_code_out));
endmodule

bind vr_fault_and_sequence_supervisor vr_sup_asserts #(.PHASES(PHASES)) u_chk (.*);

/* sim/vr_partner_model.sv */
// Processor code source and external gate driver pair.
// Assumes the supervisor clock; codes step one count at a time.
`timescale 1ns/100ps
module vr_partner_model
  import vr_sup_pkg::*;
#(
  parameter int unsigned PHASES = PHASE_MAX,
  parameter int unsigned STEP = 300
) (
  input wire logic sys_clk_in,
  input wire logic [CODE_W-1:0] target_in,
  input wire logic [PHASES-1:0] pwm_in,
  input wire logic driver_off_input_n_in,
  output logic [CODE_W-1:0] code_out,
  output logic [PHASES-1:0] high_side_gate_drive_out,
  output logic [PHASES-1:0] low_side_gate_drive_out
);
  int cnt = 0;
  initial code_out = 6'h10;
  // Walks through every intermediate code, up or down
  always @(posedge sys_clk_in) begin
    if (code_out == target_in) begin
      cnt <= 0;
    end else if (cnt == 0) begin
      code_out <= (target_in > code_out) ? code_out + 1'b1 : code_out - 1'b1;
      cnt <= STEP - 1;
    end else begin
      cnt <= cnt - 1;
    end
  end
  // Limit-set pin low forces both gate drives low
  assign high_side_gate_drive_out = driver_off_input_n_in ? pwm_in : '0;
  assign low_side_gate_drive_out = driver_off_input_n_in ? ~pwm_in : '0;
endmodule

/* sim/vr_fault_and_sequence_supervisor_tb_top.sv */
// Self-checking bench for the regulator supervisor.
// Assumes the partner model for codes and drivers, 10 MHz clock.
`timescale 1ns/100ps
module vr_fault_and_sequence_supervisor_tb_top;
  import vr_sup_pkg::*;
  logic sys_clk_in = 1'b0, rst_n_in = 1'b0, enable_in = 1'b0, current_limit_cmp_in = 1'b0;
  logic ramp_above_2v8_in = 1'b0, ramp_below_1v8_in = 1'b0, ramp_at_top_in = 1'b0;
  logic out_in_window_in = 1'b0, out_over_limit_in = 1'b0, out_below_200mv_in = 1'b0;
  logic out_below_700mv_in = 1'b1;
  logic [3:0] pwm_request_in = 4'hA, s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hF, pwm_enable_out, phase_tick_out, hs, ls;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic output_good_flag_out, output_good_flag_oe_n_out, ramp_charge_out, ramp_pullup_out;
  logic ramp_short_out, limit_set_pin_out, limit_active_out, startup_clamp_out;
  logic [CODE_W-1:0] dac_code_out, voltage_code_inputs_in, target = 6'h10;
  int errors = 0, n_tests = 0, cycles = 0;

  vr_fault_and_sequence_supervisor DUT (.*);
  vr_partner_model u_partner (
    .sys_clk_in(sys_clk_in), .target_in(target), .pwm_in(pwm_enable_out),
    .driver_off_input_n_in(limit_set_pin_out), .code_out(voltage_code_inputs_in),
    .high_side_gate_drive_out(hs), .low_side_gate_drive_out(ls));

  always #50 sys_clk_in = ~sys_clk_in;

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic st(input logic [2:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(REG_STATUS, d, r);
    chk("state", d[2:0], e);
  endtask

  task automatic t_bus;
    logic [31:0] d;
    logic [1:0] r;
    rd(REG_CTRL, d, r);
    chk("ctrl", d, {16'h0, CLK_DIV_RST, 6'h0, PHASE_SEL_RST});
    rd(4'hC, d, r);
    chk("rresp", r, RESP_SLVERR);
    wr(4'hC, 32'h0, r);
    chk("bresp", r, RESP_SLVERR);
    rd(REG_STATUS, d, r);
    chk("status", d[4:0], 5'h0);
    $display("t_bus done");
  endtask

  task automatic t_start;
    enable_in <= 1'b1;
    out_below_200mv_in <= 1'b1;
    out_in_window_in <= 1'b1;
    cyc(10);
    chk("charge", ramp_charge_out, 1'b1);
    chk("clamp2v", startup_clamp_out, 1'b1);
    chk("good_early", output_good_flag_oe_n_out, 1'b0);
    st(3'h1);
    out_below_200mv_in <= 1'b0;
    ramp_above_2v8_in <= 1'b1;
    ramp_at_top_in <= 1'b1;
    cyc(10);
    chk("clamp2v_off", startup_clamp_out, 1'b0);
    chk("good", output_good_flag_oe_n_out, 1'b1);
    chk("pwm", pwm_enable_out, 4'h2);
    st(3'h2);
    $display("t_start done");
  endtask

  task automatic t_phase;
    int n;
    logic [1:0] r;
    for (int s = 1; s < 4; s += 2) begin
      wr(REG_CTRL, {16'h0, CLK_DIV_RST, 6'h0, 2'(s)}, r);
      cyc(50);
      n = 0;
      repeat (200 * (s + 1)) begin
        @(posedge sys_clk_in);
        n += int'(phase_tick_out[0]);
      end
      chk("ticks", n, 20);
    end
    $display("t_phase done");
  endtask

  task automatic t_code;
    logic [31:0] d;
    logic [1:0] r;
    target <= 6'h13;
    cyc(620);
    chk("code", dac_code_out, 6'h13);
    out_in_window_in <= 1'b0;
    cyc(10);
    chk("good_blank", output_good_flag_oe_n_out, 1'b1);
    cyc(2260);
    rd(REG_STATUS, d, r);
    chk("blank_held", d[6], 1'b1);
    cyc(300);
    rd(REG_STATUS, d, r);
    chk("blank_end", d[6], 1'b0);
    chk("good_end", output_good_flag_oe_n_out, 1'b0);
    out_in_window_in <= 1'b1;
    $display("t_code done");
  endtask

  task automatic t_clamp;
    pwm_request_in <= 4'hF;
    out_over_limit_in <= 1'b1;
    out_below_700mv_in <= 1'b0;
    cyc(3);
    out_over_limit_in <= 1'b0;
    cyc(5);
    chk("clamp_hold", pwm_enable_out, 4'h0);
    out_below_700mv_in <= 1'b1;
    cyc(5);
    chk("clamp_free", pwm_enable_out, 4'hF);
    $display("t_clamp done");
  endtask

  task automatic t_limit;
    pwm_request_in <= 4'h5;
    current_limit_cmp_in <= 1'b1;
    cyc(4);
    chk("limit", limit_active_out, 1'b1);
    chk("pullup", ramp_pullup_out, 1'b0);
    chk("cycling", pwm_enable_out, 4'h5);
    current_limit_cmp_in <= 1'b0;
    cyc(3);
    st(3'h2);
    current_limit_cmp_in <= 1'b1;
    cyc(3);
    out_in_window_in <= 1'b0;
    ramp_at_top_in <= 1'b0;
    ramp_above_2v8_in <= 1'b0;
    current_limit_cmp_in <= 1'b0;
    cyc(2);
    st(3'h1);
    out_in_window_in <= 1'b1;
    ramp_at_top_in <= 1'b1;
    ramp_above_2v8_in <= 1'b1;
    cyc(5);
    $display("t_limit done");
  endtask

  task automatic t_latch;
    current_limit_cmp_in <= 1'b1;
    cyc(3);
    ramp_below_1v8_in <= 1'b1;
    cyc(4);
    chk("latched_pwm", pwm_enable_out, 4'h0);
    current_limit_cmp_in <= 1'b0;
    ramp_below_1v8_in <= 1'b0;
    cyc(5);
    st(3'h4);
    enable_in <= 1'b0;
    ramp_at_top_in <= 1'b0;
    cyc(3);
    chk("short", ramp_short_out, 1'b1);
    chk("limit_pin", limit_set_pin_out, 1'b0);
    chk("good_off", output_good_flag_oe_n_out, 1'b0);
    chk("good_data", output_good_flag_out, 1'b0);
    chk("gates", hs | ls, 4'h0);
    st(3'h0);
    enable_in <= 1'b1;
    cyc(3);
    st(3'h1);
    $display("t_latch done");
  endtask

  initial begin
    cyc(3);
    rst_n_in <= 1'b1;
    t_bus();
    t_start();
    t_phase();
    t_code();
    t_clamp();
    t_limit();
    t_latch();
    stop_test();
  end
endmodule
